//--- core/power_control_pkg.sv
// Package: register map, field layout and carrier types of the power control bank
package power_control_pkg;
  localparam logic [11:0] OFS_CONST_TRIG   = 12'h078;
  localparam logic [11:0] OFS_LOW_TRIG     = 12'h07c;
  localparam logic [11:0] OFS_CONST_SUB    = 12'h0f8;
  localparam logic [11:0] OFS_LOW_SUB      = 12'h0fc;
  localparam logic [11:0] OFS_WARN_FLAG    = 12'h108;
  localparam logic [11:0] OFS_SENTRY_FLAG  = 12'h114;
  localparam logic [11:0] OFS_SEXIT_FLAG   = 12'h118;
  localparam logic [11:0] OFS_WARN_PUB     = 12'h188;
  localparam logic [11:0] OFS_SENTRY_PUB   = 12'h194;
  localparam logic [11:0] OFS_SEXIT_PUB    = 12'h198;
  localparam logic [11:0] OFS_IRQ_EN       = 12'h300;
  localparam logic [11:0] OFS_IRQ_EN_SET   = 12'h304;
  localparam logic [11:0] OFS_IRQ_EN_CLR   = 12'h308;
  localparam logic [11:0] OFS_RESET_CAUSE  = 12'h400;
  localparam logic [11:0] OFS_MODEM_PWR    = 12'h440;
  localparam logic [11:0] OFS_SCRATCH0     = 12'h51c;
  localparam logic [11:0] OFS_SCRATCH1     = 12'h520;

  localparam int CHAN_W     = 16;
  localparam int CHAN_COUNT = 16;
  localparam int EN_BIT     = 31;
  localparam int IRQ_WARN   = 2;
  localparam int IRQ_SENTRY = 5;
  localparam int IRQ_SEXIT  = 6;

  localparam logic [31:0] RESET_ZERO     = 32'h0000_0000;
  localparam logic [31:0] SUB_MASK       = 32'h8000_ffff;
  localparam logic [31:0] IRQ_MASK       = 32'h0000_0064;

  typedef struct packed {
    logic        en;
    logic [15:0] channelIndex;
  } sub_cfg_t;

  typedef struct packed {
    logic supplyWarning;
    logic sleepEntry;
    logic sleep_exit_event;
  } events_t;
endpackage

//--- core/power_control_regs.sv
// Power control register bank: tasks, subscriptions, event flags, shared irq enables
//
// Functional notes
// - Writing 1 to constant-latency trigger starts task
// - Writing 1 to low-power trigger starts task
// - Constant-latency subscription: channel index, enable bit
// - Low-power subscription gated by enable, resets zero
// - Irq enable registers shared with clock unit
// - One bank exposes tasks, events, enables, warning
//
// Chosen here: the APB interface to the registers.
`timescale 1ns/10ps
module power_control_regs (
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  input  wire logic [3:0]  pstrb,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic [15:0] channelEvents,
  input  wire power_control_pkg::events_t hwEvents,
  input  wire logic [31:0] resetCauseIn,
  input  wire logic        resetCauseLoad,
  input  wire logic [31:0] modemPowerState,
  input  wire logic        clockUnitEnWrite,
  input  wire logic [31:0] clockUnitEnData,
  output logic             constantLatencyTask,
  output logic             lowPowerTask,
  output power_control_pkg::events_t publishEvents,
  output logic [31:0]      irqEnableShared,
  output logic             irq
);
  power_control_pkg::sub_cfg_t constSub;
  power_control_pkg::sub_cfg_t lowSub;
  power_control_pkg::events_t  flags;
  logic [31:0] warnPub;
  logic [31:0] entryPub;
  logic [31:0] exitPub;
  logic [31:0] irqEnable;
  logic [31:0] resetCause;
  logic [31:0] scratch0;
  logic [31:0] scratch1;

  // Bus decode; one-cycle answer, pready is a flop so setup cycle precedes it
  wire logic access = psel & penable & ~pready;
  wire logic wrAcc  = access & pwrite;
  wire logic rdAcc  = access & ~pwrite;

  function automatic logic hit(input logic [11:0] a, input logic [11:0] ofs);
    return a == ofs;
  endfunction

  function automatic logic chanFires(input power_control_pkg::sub_cfg_t s,
                                     input logic [15:0] ev);
    // Out-of-range channel indices never fire
    return s.en && (s.channelIndex < 16'(power_control_pkg::CHAN_COUNT))
           && ev[s.channelIndex[3:0]];
  endfunction

  wire logic mapped = hit(paddr, power_control_pkg::OFS_CONST_TRIG)
    | hit(paddr, power_control_pkg::OFS_LOW_TRIG)
    | hit(paddr, power_control_pkg::OFS_CONST_SUB)
    | hit(paddr, power_control_pkg::OFS_LOW_SUB)
    | hit(paddr, power_control_pkg::OFS_WARN_FLAG)
    | hit(paddr, power_control_pkg::OFS_SENTRY_FLAG)
    | hit(paddr, power_control_pkg::OFS_SEXIT_FLAG)
    | hit(paddr, power_control_pkg::OFS_WARN_PUB)
    | hit(paddr, power_control_pkg::OFS_SENTRY_PUB)
    | hit(paddr, power_control_pkg::OFS_SEXIT_PUB)
    | hit(paddr, power_control_pkg::OFS_IRQ_EN)
    | hit(paddr, power_control_pkg::OFS_IRQ_EN_SET)
    | hit(paddr, power_control_pkg::OFS_IRQ_EN_CLR)
    | hit(paddr, power_control_pkg::OFS_RESET_CAUSE)
    | hit(paddr, power_control_pkg::OFS_MODEM_PWR)
    | hit(paddr, power_control_pkg::OFS_SCRATCH0)
    | hit(paddr, power_control_pkg::OFS_SCRATCH1);

  // Byte-lane writes; partial strobes are applied lane by lane
  wire logic [31:0] laneMask = {{8{pstrb[3]}}, {8{pstrb[2]}}, {8{pstrb[1]}}, {8{pstrb[0]}}};
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                        input logic [31:0] m);
    return (old & ~m) | (nw & m);
  endfunction

  wire logic wrConstTrig = wrAcc & hit(paddr, power_control_pkg::OFS_CONST_TRIG);
  wire logic wrLowTrig   = wrAcc & hit(paddr, power_control_pkg::OFS_LOW_TRIG);
  wire logic wrConstSub  = wrAcc & hit(paddr, power_control_pkg::OFS_CONST_SUB);
  wire logic wrLowSub    = wrAcc & hit(paddr, power_control_pkg::OFS_LOW_SUB);
  wire logic wrWarnFlag  = wrAcc & hit(paddr, power_control_pkg::OFS_WARN_FLAG);
  wire logic wrEntryFlag = wrAcc & hit(paddr, power_control_pkg::OFS_SENTRY_FLAG);
  wire logic wrExitFlag  = wrAcc & hit(paddr, power_control_pkg::OFS_SEXIT_FLAG);
  wire logic wrIrqEn     = wrAcc & hit(paddr, power_control_pkg::OFS_IRQ_EN);
  wire logic wrIrqSet    = wrAcc & hit(paddr, power_control_pkg::OFS_IRQ_EN_SET);
  wire logic wrIrqClr    = wrAcc & hit(paddr, power_control_pkg::OFS_IRQ_EN_CLR);
  wire logic wrResetCause = wrAcc & hit(paddr, power_control_pkg::OFS_RESET_CAUSE);

  // Task triggers: software write of 1 or a subscribed channel event
  wire logic next_constTask = (wrConstTrig & pstrb[0] & pwdata[0])
                            | chanFires(constSub, channelEvents);
  wire logic next_lowTask   = (wrLowTrig & pstrb[0] & pwdata[0])
                            | chanFires(lowSub, channelEvents);

  // Subscription registers keep only channel field and enable bit
  wire logic [31:0] constSubWord = {constSub.en, 15'h0000, constSub.channelIndex};
  wire logic [31:0] lowSubWord   = {lowSub.en, 15'h0000, lowSub.channelIndex};
  wire logic [31:0] constSubNew  = merge(constSubWord, pwdata, laneMask)
                                   & power_control_pkg::SUB_MASK;
  wire logic [31:0] lowSubNew    = merge(lowSubWord, pwdata, laneMask)
                                   & power_control_pkg::SUB_MASK;

  // Flag clear: writing 0 clears; a same-cycle event still sets
  wire logic clrWarn  = wrWarnFlag  & pstrb[0] & ~pwdata[0];
  wire logic clrEntry = wrEntryFlag & pstrb[0] & ~pwdata[0];
  wire logic clrExit  = wrExitFlag  & pstrb[0] & ~pwdata[0];
  wire power_control_pkg::events_t next_flags = '{
    supplyWarning: hwEvents.supplyWarning | (flags.supplyWarning & ~clrWarn),
    sleepEntry:    hwEvents.sleepEntry    | (flags.sleepEntry & ~clrEntry),
    sleep_exit_event:     hwEvents.sleep_exit_event     | (flags.sleep_exit_event & ~clrExit)
  };

  // Shared enable: either unit may write; clock-unit write applied after ours
  wire logic [31:0] enAfterBus = wrIrqEn  ? merge(irqEnable, pwdata, laneMask)
                               : wrIrqSet ? (irqEnable | (pwdata & laneMask))
                               : wrIrqClr ? (irqEnable & ~(pwdata & laneMask))
                               : irqEnable;
  wire logic [31:0] next_irqEnable = clockUnitEnWrite ? clockUnitEnData : enAfterBus;

  wire logic next_irq =
      (next_flags.supplyWarning & next_irqEnable[power_control_pkg::IRQ_WARN])
    | (next_flags.sleepEntry    & next_irqEnable[power_control_pkg::IRQ_SENTRY])
    | (next_flags.sleep_exit_event     & next_irqEnable[power_control_pkg::IRQ_SEXIT]);

  // Read mux; trigger registers are write-only and read zero
  wire logic [31:0] rdWord =
      hit(paddr, power_control_pkg::OFS_CONST_SUB)   ? constSubWord :
      hit(paddr, power_control_pkg::OFS_LOW_SUB)     ? lowSubWord :
      hit(paddr, power_control_pkg::OFS_WARN_FLAG)   ? {31'h0, flags.supplyWarning} :
      hit(paddr, power_control_pkg::OFS_SENTRY_FLAG) ? {31'h0, flags.sleepEntry} :
      hit(paddr, power_control_pkg::OFS_SEXIT_FLAG)  ? {31'h0, flags.sleep_exit_event} :
      hit(paddr, power_control_pkg::OFS_WARN_PUB)    ? warnPub :
      hit(paddr, power_control_pkg::OFS_SENTRY_PUB)  ? entryPub :
      hit(paddr, power_control_pkg::OFS_SEXIT_PUB)   ? exitPub :
      (hit(paddr, power_control_pkg::OFS_IRQ_EN) | hit(paddr, power_control_pkg::OFS_IRQ_EN_SET)
       | hit(paddr, power_control_pkg::OFS_IRQ_EN_CLR)) ? irqEnable :
      hit(paddr, power_control_pkg::OFS_RESET_CAUSE) ? resetCause :
      hit(paddr, power_control_pkg::OFS_MODEM_PWR)   ? modemPowerState :
      hit(paddr, power_control_pkg::OFS_SCRATCH0)    ? scratch0 :
      hit(paddr, power_control_pkg::OFS_SCRATCH1)    ? scratch1 :
      power_control_pkg::RESET_ZERO;

  // Reset cause: hardware load wins; software writes 1 to clear bits
  wire logic [31:0] next_resetCause = resetCauseLoad ? resetCauseIn
      : wrResetCause ? (resetCause & ~(pwdata & laneMask)) : resetCause;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= power_control_pkg::RESET_ZERO;
    end else begin
      pready  <= access;
      pslverr <= access & ~mapped;
      prdata  <= (rdAcc & mapped) ? rdWord : power_control_pkg::RESET_ZERO;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      constSub <= '0;
      lowSub   <= '0;
    end else begin
      if (wrConstSub) begin
        constSub <= '{en: constSubNew[power_control_pkg::EN_BIT],
                      channelIndex: constSubNew[15:0]};
      end
      if (wrLowSub) begin
        lowSub <= '{en: lowSubNew[power_control_pkg::EN_BIT],
                    channelIndex: lowSubNew[15:0]};
      end
    end
  end

  // Write strobes of the plain storage registers
  wire logic wrWarnPub  = wrAcc & hit(paddr, power_control_pkg::OFS_WARN_PUB);
  wire logic wrEntryPub = wrAcc & hit(paddr, power_control_pkg::OFS_SENTRY_PUB);
  wire logic wrExitPub  = wrAcc & hit(paddr, power_control_pkg::OFS_SEXIT_PUB);
  wire logic wrScratch0 = wrAcc & hit(paddr, power_control_pkg::OFS_SCRATCH0);
  wire logic wrScratch1 = wrAcc & hit(paddr, power_control_pkg::OFS_SCRATCH1);

  // Task pulses last one cycle; nothing stretches them
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      constantLatencyTask <= 1'b0;
      lowPowerTask        <= 1'b0;
    end else begin
      constantLatencyTask <= next_constTask;
      lowPowerTask        <= next_lowTask;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      flags <= '0;
    end else begin
      flags <= next_flags;
    end
  end

  // Publish mirrors the raw event, not the sticky flag
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      publishEvents <= '0;
    end else begin
      publishEvents <= '{supplyWarning: hwEvents.supplyWarning & warnPub[31],
                         sleepEntry:    hwEvents.sleepEntry & entryPub[31],
                         sleep_exit_event:     hwEvents.sleep_exit_event & exitPub[31]};
    end
  end

  // Local copy and port copy stay equal so both units read one word
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      irqEnable       <= power_control_pkg::RESET_ZERO;
      irqEnableShared <= power_control_pkg::RESET_ZERO;
    end else begin
      irqEnable       <= next_irqEnable;
      irqEnableShared <= next_irqEnable;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      irq <= 1'b0;
    end else begin
      irq <= next_irq;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      resetCause <= power_control_pkg::RESET_ZERO;
    end else begin
      resetCause <= next_resetCause;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      warnPub <= power_control_pkg::RESET_ZERO;
    end else if (wrWarnPub) begin
      warnPub <= merge(warnPub, pwdata, laneMask) & power_control_pkg::SUB_MASK;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      entryPub <= power_control_pkg::RESET_ZERO;
    end else if (wrEntryPub) begin
      entryPub <= merge(entryPub, pwdata, laneMask) & power_control_pkg::SUB_MASK;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      exitPub <= power_control_pkg::RESET_ZERO;
    end else if (wrExitPub) begin
      exitPub <= merge(exitPub, pwdata, laneMask) & power_control_pkg::SUB_MASK;
    end
  end

  // Scratch words are cleared by any reset of this bank
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      scratch0 <= power_control_pkg::RESET_ZERO;
    end else if (wrScratch0) begin
      scratch0 <= merge(scratch0, pwdata, laneMask);
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      scratch1 <= power_control_pkg::RESET_ZERO;
    end else if (wrScratch1) begin
      scratch1 <= merge(scratch1, pwdata, laneMask);
    end
  end
endmodule

//--- testbench/power_control_regs_asserts.sv
// Checker: APB answer timing, task triggers, shared enables and warning interrupt
`timescale 1ns/10ps
module power_control_regs_asserts (
  input wire logic                       clk,
  input wire logic                       rst_n,
  input wire logic                       psel,
  input wire logic                       penable,
  input wire logic                       pwrite,
  input wire logic [11:0]                paddr,
  input wire logic [31:0]                pwdata,
  input wire logic [3:0]                 pstrb,
  input wire logic [31:0]                prdata,
  input wire logic                       pready,
  input wire logic                       pslverr,
  input wire power_control_pkg::events_t hwEvents,
  input wire logic                       clockUnitEnWrite,
  input wire logic [31:0]                clockUnitEnData,
  input wire logic                       constantLatencyTask,
  input wire logic                       lowPowerTask,
  input wire logic [31:0]                irqEnableShared,
  input wire logic                       irq
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  sequence s_taken; psel && penable && !pready; endsequence
  sequence s_trig(logic [11:0] a); s_taken ##0 (pwrite && paddr == a && pstrb[0] && pwdata[0]);
  endsequence
  property p_const_trig; s_trig(power_control_pkg::OFS_CONST_TRIG) |=> constantLatencyTask;
  endproperty
  property p_low_trig; s_trig(power_control_pkg::OFS_LOW_TRIG) |=> lowPowerTask; endproperty
  property p_answer; s_taken |=> pready; endproperty
  property p_ready_once; pready |=> !pready; endproperty
  property p_unmapped; pready && pslverr |-> prdata == 32'h0000_0000; endproperty
  property p_trig_read; pready && !pwrite && (paddr == 12'h078 || paddr == 12'h07c)
    |-> prdata == 32'h0000_0000; endproperty
  property p_shared; clockUnitEnWrite |=> (irqEnableShared & power_control_pkg::IRQ_MASK)
    == ($past(clockUnitEnData) & power_control_pkg::IRQ_MASK); endproperty
  // Bus writes could change the enable at the same edge, so they are excluded
  property p_irq; hwEvents.supplyWarning && irqEnableShared[power_control_pkg::IRQ_WARN]
    && !clockUnitEnWrite && !psel |=> irq; endproperty
  a_const_trig: assert property (p_const_trig) else $error("constant latency task missing");
  a_low_trig: assert property (p_low_trig) else $error("low power task missing");
  a_answer: assert property (p_answer) else $error("pready late");
  a_ready_once: assert property (p_ready_once) else $error("pready too long");
  a_unmapped: assert property (p_unmapped) else $error("error read not zero");
  a_trig_read: assert property (p_trig_read) else $error("trigger read not zero");
  a_shared: assert property (p_shared) else $error("shared enable not loaded");
  a_irq: assert property (p_irq) else $error("irq not raised");
endmodule
bind power_control_regs power_control_regs_asserts u_chk (.clk(clk), .rst_n(rst_n),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
  .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr), .hwEvents(hwEvents),
  .clockUnitEnWrite(clockUnitEnWrite), .clockUnitEnData(clockUnitEnData),
  .constantLatencyTask(constantLatencyTask), .lowPowerTask(lowPowerTask),
  .irqEnableShared(irqEnableShared), .irq(irq));

//--- testbench/tb_top.sv
// Testbench: directed register, trigger, subscription and event scenarios
`timescale 1ns/10ps
module tb_top;
  logic        clk = 1'b0, rst_n = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, clockUnitEnData = 32'h0, prdata, irqEnableShared;
  logic [15:0] channelEvents = 16'h0;
  logic        clockUnitEnWrite = 1'b0, pready, pslverr, constantLatencyTask, lowPowerTask, irq;
  power_control_pkg::events_t hwEvents = '0, publishEvents;
  int          errors = 0, checks_done = 0, cycles = 0, constCount = 0, lowCount = 0;

  always #50 clk = ~clk;

  power_control_regs dut (.clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(4'hf), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .channelEvents(channelEvents), .hwEvents(hwEvents),
    .resetCauseIn(32'h0), .resetCauseLoad(1'b0), .modemPowerState(32'h0),
    .clockUnitEnWrite(clockUnitEnWrite), .clockUnitEnData(clockUnitEnData),
    .constantLatencyTask(constantLatencyTask), .lowPowerTask(lowPowerTask),
    .publishEvents(publishEvents), .irqEnableShared(irqEnableShared), .irq(irq));

  task automatic close_out;
    $display("errors %0d checks %0d", errors, checks_done);
    if (errors == 0 && checks_done > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask

  // Hang guard: the whole run needs well under a thousand cycles
  always @(posedge clk) begin
    if (constantLatencyTask === 1'b1) constCount++;
    if (lowPowerTask === 1'b1) lowCount++;
    if (++cycles == 5000) begin
      errors++;
      close_out();
    end
  end

  task automatic chk(input string n, input logic [31:0] x, input logic [31:0] g);
    checks_done++;
    if (g !== x) begin
      errors++;
      $display("mismatch %s expected %h seen %h", n, x, g);
    end
  endtask

  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                     output logic [31:0] r, output logic e);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic        e;
    apb(1'b1, a, d, r, e);
  endtask

  task automatic rd(input logic [11:0] a, input logic [31:0] x, input string n);
    logic [31:0] r;
    logic        e;
    apb(1'b0, a, 32'h0, r, e);
    chk(n, x, r);
  endtask

  task automatic ev_ch(input int n);
    channelEvents <= 16'h0001 << n;
    @(posedge clk);
    channelEvents <= 16'h0;
    repeat (3) @(posedge clk);
  endtask

  task automatic t_reset_vals;
    rd(12'h0fc, 32'h0, "low_power_sub_cfg");
    rd(12'h0f8, 32'h0, "constant_latency_sub_cfg");
    rd(12'h108, 32'h0, "supply_warning_flag");
    rd(12'h078, 32'h0, "constant_latency_trigger");
  endtask

  task automatic t_trig;
    int c0, l0;
    c0 = constCount;
    l0 = lowCount;
    wr(12'h078, 32'h1);
    wr(12'h07c, 32'h1);
    wr(12'h078, 32'h0);
    repeat (2) @(posedge clk);
    chk("constant_latency_task", 32'(c0 + 1), 32'(constCount));
    chk("low_power_task", 32'(l0 + 1), 32'(lowCount));
  endtask

  task automatic t_sub;
    int c0, l0;
    c0 = constCount;
    l0 = lowCount;
    wr(12'h0f8, 32'h8000_0005);
    wr(12'h0fc, 32'h8000_000f);
    rd(12'h0f8, 32'h8000_0005, "constant_latency_sub_cfg");
    ev_ch(5);
    ev_ch(4);
    ev_ch(15);
    chk("low_power_task", 32'(l0 + 1), 32'(lowCount));
    wr(12'h0f8, 32'h0000_0005);
    ev_ch(5);
    chk("constant_latency_task", 32'(c0 + 1), 32'(constCount));
  endtask

  task automatic t_events;
    wr(12'h304, 32'h0000_0004);
    rd(12'h300, 32'h0000_0004, "irq_enable");
    hwEvents <= 3'b100;
    @(posedge clk);
    hwEvents <= '0;
    repeat (3) @(posedge clk);
    chk("irq", 32'h1, {31'h0, irq});
    rd(12'h108, 32'h1, "supply_warning_flag");
    wr(12'h108, 32'h0);
    repeat (2) @(posedge clk);
    chk("irq", 32'h0, {31'h0, irq});
    wr(12'h308, 32'h0000_0004);
    rd(12'h300, 32'h0, "irq_enable");
  endtask

  task automatic t_publish;
    wr(12'h188, 32'h8000_0000);
    rd(12'h188, 32'h8000_0000, "supply_warning_pub_cfg");
    hwEvents <= 3'b110;
    @(posedge clk);
    hwEvents <= '0;
    @(negedge clk);
    chk("publishEvents", 32'h4, {29'h0, publishEvents});
    @(posedge clk);
    rd(12'h114, 32'h1, "sleep_entry_flag");
    rd(12'h118, 32'h0, "sleep_exit_flag");
    wr(12'h51c, 32'ha5a5_0f0f);
    rd(12'h51c, 32'ha5a5_0f0f, "retained_scratch_0");
  endtask

  task automatic t_shared_unmapped;
    logic [31:0] r;
    logic        e;
    clockUnitEnData <= 32'h0000_0060;
    clockUnitEnWrite <= 1'b1;
    @(posedge clk);
    clockUnitEnWrite <= 1'b0;
    repeat (2) @(posedge clk);
    rd(12'h300, 32'h0000_0060, "irq_enable");
    apb(1'b0, 12'h004, 32'h0, r, e);
    chk("pslverr", 32'h1, {31'h0, e});
    chk("prdata", 32'h0, r);
  endtask

  initial begin
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    t_reset_vals();
    t_trig();
    t_sub();
    t_events();
    t_publish();
    t_shared_unmapped();
    close_out();
  end
endmodule
